// *** rtl/pscd_pkg.sv ***
// Purpose: Constants for the PHY special control and cable diagnostic register bank
// Assumes: 16-bit registers on a plain strobe port, byte offsets within the bank
// Notes:   Shared by the design and the bench
package pscd_pkg;
   // Register offsets
   localparam logic [7:0]  PSCD_OFS_PHY1_CTRL   = 8'h02;
   localparam logic [7:0]  PSCD_OFS_PHY2_DIAG   = 8'h04;
   localparam logic [7:0]  PSCD_OFS_PHY2_CTRL   = 8'h06;
   localparam logic [7:0]  PSCD_OFS_IRQ_STATUS  = 8'h08;
   localparam logic [7:0]  PSCD_OFS_IRQ_ENABLE  = 8'h0a;
   localparam logic [7:0]  PSCD_OFS_IRQ_CLEAR   = 8'h0c;
   // Special control/status fields
   localparam int          PSCD_BIT_POLRV       = 5;
   localparam int          PSCD_BIT_XOVER       = 4;
   localparam int          PSCD_BIT_FLINK       = 3;
   localparam int          PSCD_BIT_PSAVE_DIS   = 2;
   localparam int          PSCD_BIT_LOOP        = 1;
   localparam logic [2:0]  PSCD_CTRL_RST        = 3'h2; // force, psave_dis, loop
   // Diagnostic fields
   localparam int          PSCD_BIT_DSTART      = 15;
   localparam int          PSCD_BIT_DRES_HI     = 14;
   localparam int          PSCD_BIT_DRES_LO     = 13;
   localparam int          PSCD_BIT_SHORT10     = 12;
   localparam int          PSCD_DCNT_W          = 9;
   localparam logic [1:0]  PSCD_RES_NORMAL      = 2'h0;
   localparam logic [1:0]  PSCD_RES_OPEN        = 2'h1;
   localparam logic [1:0]  PSCD_RES_SHORT       = 2'h2;
   localparam logic [1:0]  PSCD_RES_FAIL        = 2'h3;
   // Interrupt status bits
   localparam int          PSCD_IRQ_DIAG_DONE   = 0;
   localparam int          PSCD_IRQ_POL1        = 1;
   localparam int          PSCD_IRQ_POL2        = 2;
   localparam int          PSCD_IRQ_W           = 3;
   // Diagnostic engine states
   typedef enum logic [2:0] {
      PSCD_ST_IDLE = 3'b001,
      PSCD_ST_REQ  = 3'b010,
      PSCD_ST_WAIT = 3'b100
   } pscd_state_t;
endpackage

// *** rtl/pscd_bank.sv ***
// Purpose: PHY special control/status and port 2 cable diagnostic register bank
// Assumes: PHY status inputs from the analog front end are asynchronous
// Notes:   Diagnostic engine handshake (start/done) runs on clk_i
//
// How it works
// - Bit 5 shows receive polarity reversed
// - Bit 4 shows crossover: 1 MDI, 0 MDIX
// - Bit 3 forces link pass, reset 0
// - Bit 2 set disables power saving, reset 1
// - Port 1 bit 1 loops receive to transmit
// - Port 2 bit 1 loops receive to transmit
// - Port 1 control register at 0x02
// - Port 2 control register at 0x06, same layout
// - Cable diagnostic register at 0x04
// - Writing bit 15 starts test, self-clears
// - Results updated on the same clock edge as bit 15 clears
// - Bits 14:13 give normal, open, short, fail
// - Bit 12 flags short under ten metres
// - Bits 8:0 give fault distance count
`timescale 1ns/1ps
module pscd_bank
   import pscd_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   srst_i,
   // Register port
   input  wire logic [7:0]             addr_i,
   input  wire logic [15:0]            wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic      [15:0]            rdata_o,
   output logic                        irq_o,
   // PHY status from the front end (asynchronous)
   input  wire logic [1:0]             polarity_reversed_i,
   input  wire logic [1:0]             crossover_state_i,
   // PHY controls
   output logic      [1:0]             force_link_pass_o,
   output logic      [1:0]             power_save_disable_o,
   output logic      [1:0]             near_end_loopback_o,
   // Port 2 cable diagnostic engine
   output logic                        diag_start_o,
   input  wire logic                   diag_done_i,
   input  wire logic [1:0]             diag_result_i,
   input  wire logic                   diag_short_within_ten_metres_i,
   input  wire logic [PSCD_DCNT_W-1:0] diag_fault_count_i
);

   // Synchronisers for the front-end status
   logic [3:0]             sync_meta;
   logic [3:0]             sync_q;
   wire  [1:0]             pol_s = sync_q[1:0];
   wire  [1:0]             xov_s = sync_q[3:2];

   // Control and diagnostic state
   logic [2:0]             ctrl1;
   logic [2:0]             ctrl2;
   pscd_state_t            state;
   pscd_state_t            next_state;
   logic [1:0]             res;
   logic                   short10;
   logic [PSCD_DCNT_W-1:0] fcnt;
   logic [PSCD_IRQ_W-1:0]  irq_stat;
   logic [PSCD_IRQ_W-1:0]  irq_en;
   logic [1:0]             pol_d;

   // Address decode
   wire  sel_c1  = (addr_i == PSCD_OFS_PHY1_CTRL);
   wire  sel_dg  = (addr_i == PSCD_OFS_PHY2_DIAG);
   wire  sel_c2  = (addr_i == PSCD_OFS_PHY2_CTRL);
   wire  sel_ist = (addr_i == PSCD_OFS_IRQ_STATUS);
   wire  sel_ien = (addr_i == PSCD_OFS_IRQ_ENABLE);
   wire  sel_icl = (addr_i == PSCD_OFS_IRQ_CLEAR);
   wire  busy    = (state != PSCD_ST_IDLE);
   wire  start_w = wr_i && sel_dg && wdata_i[PSCD_BIT_DSTART] && !busy;
   wire  done_w  = (state == PSCD_ST_WAIT) && diag_done_i;

   // Build a control/status read word, identical layout for both ports
   function automatic logic [15:0] ctrl_word(input logic pol, input logic xov,
                                             input logic [2:0] c);
      logic [15:0] w;
      w = 16'h0000;
      w[PSCD_BIT_POLRV] = pol;
      w[PSCD_BIT_XOVER] = xov;
      w[PSCD_BIT_FLINK] = c[2];
      w[PSCD_BIT_PSAVE_DIS] = c[1];
      w[PSCD_BIT_LOOP] = c[0];
      return w;
   endfunction

   // Diagnostic read word
   wire [15:0] diag_word = {busy, res, short10, 3'h0, fcnt};

   // Read mux, unmapped reads return zero
   wire [15:0] rd_mux =
      sel_c1  ? ctrl_word(pol_s[0], xov_s[0], ctrl1) :
      sel_c2  ? ctrl_word(pol_s[1], xov_s[1], ctrl2) :
      sel_dg  ? diag_word :
      sel_ist ? {13'h0000, irq_stat} :
      sel_ien ? {13'h0000, irq_en} : 16'h0000;

   // Interrupt events: test finished, polarity changed
   wire [PSCD_IRQ_W-1:0] irq_evt = {pol_s[1] ^ pol_d[1], pol_s[0] ^ pol_d[0], done_w};
   wire [PSCD_IRQ_W-1:0] irq_clr = (wr_i && sel_icl) ? wdata_i[PSCD_IRQ_W-1:0] : '0;

   // Diagnostic sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         PSCD_ST_IDLE: if (start_w) next_state = PSCD_ST_REQ;
         PSCD_ST_REQ:  next_state = PSCD_ST_WAIT;
         PSCD_ST_WAIT: if (diag_done_i) next_state = PSCD_ST_IDLE;
         default:      next_state = PSCD_ST_IDLE;
      endcase
   end

   // Status synchronisers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sync_meta <= 4'h0;
         sync_q    <= 4'h0;
      end else begin
         sync_meta <= {crossover_state_i, polarity_reversed_i};
         sync_q    <= sync_meta;
      end
   end

   // Control registers, writable bits only
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl1 <= PSCD_CTRL_RST;
         ctrl2 <= PSCD_CTRL_RST;
      end else if (wr_i) begin
         if (sel_c1)
            ctrl1 <= wdata_i[PSCD_BIT_FLINK:PSCD_BIT_LOOP];
         if (sel_c2)
            ctrl2 <= wdata_i[PSCD_BIT_FLINK:PSCD_BIT_LOOP];
      end
   end

   // Diagnostic state and result capture
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state   <= PSCD_ST_IDLE;
         res     <= PSCD_RES_NORMAL;
         short10 <= 1'b0;
         fcnt    <= '0;
      end else begin
         state <= next_state;
         if (done_w) begin
            res     <= diag_result_i;
            short10 <= diag_short_within_ten_metres_i;
            fcnt    <= diag_fault_count_i;
         end
      end
   end

   // Interrupt status, set wins over clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_stat <= '0;
         irq_en   <= '0;
         pol_d    <= 2'h0;
      end else begin
         pol_d    <= pol_s;
         irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
         if (wr_i && sel_ien)
            irq_en <= wdata_i[PSCD_IRQ_W-1:0];
      end
   end

   // Registered outputs
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_o              <= 16'h0000;
         irq_o                <= 1'b0;
         force_link_pass_o    <= 2'h0;
         power_save_disable_o <= 2'h3;
         near_end_loopback_o  <= 2'h0;
         diag_start_o         <= 1'b0;
      end else begin
         rdata_o              <= rd_i ? rd_mux : 16'h0000;
         irq_o                <= |(irq_stat & irq_en);
         force_link_pass_o    <= {ctrl2[2], ctrl1[2]};
         power_save_disable_o <= {ctrl2[1], ctrl1[1]};
         near_end_loopback_o  <= {ctrl2[0], ctrl1[0]};
         diag_start_o         <= (next_state == PSCD_ST_REQ);
      end
   end

endmodule

// *** tb/pscd_chk.sv ***
// Purpose: Port assertions for the register bank
// Assumes: One clock, sync reset
// Notes:   Bound into pscd_bank
`timescale 1ns/1ps
module pscd_chk (
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic [7:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic [1:0]  force_link_pass_o,
   input wire logic [1:0]  power_save_disable_o,
   input wire logic [1:0]  near_end_loopback_o,
   input wire logic        diag_start_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // Reset values, start pulse, control paths and read layout
   rst_vals_a: assert property ($fell(srst_i) |-> force_link_pass_o == 2'h0 &&
      power_save_disable_o == 2'h3 && near_end_loopback_o == 2'h0 && !diag_start_o)
      else $error("bad reset outputs");
   start_pulse_a: assert property (diag_start_o |=> !diag_start_o)
      else $error("start not a pulse");
   start_cause_a: assert property (diag_start_o |->
      $past(wr_i && addr_i == 8'h04 && wdata_i[15])) else $error("start without write");
   force_one_a: assert property (wr_i && addr_i == 8'h02 |-> ##2
      force_link_pass_o[0] == $past(wdata_i[3], 2)) else $error("force link wrong");
   psave_two_a: assert property (wr_i && addr_i == 8'h06 |-> ##2
      power_save_disable_o[1] == $past(wdata_i[2], 2)) else $error("power save wrong");
   loop_one_a: assert property (wr_i && addr_i == 8'h02 |-> ##2
      near_end_loopback_o[0] == $past(wdata_i[1], 2)) else $error("loop 1 wrong");
   loop_two_a: assert property (wr_i && addr_i == 8'h06 |-> ##2
      near_end_loopback_o[1] == $past(wdata_i[1], 2)) else $error("loop 2 wrong");
   read_one_a: assert property (rd_i && addr_i == 8'h02 && !$past(wr_i) |=>
      rdata_o[3:1] == $past({force_link_pass_o[0], power_save_disable_o[0],
      near_end_loopback_o[0]}) && {rdata_o[15:6], rdata_o[0]} == 11'h0)
      else $error("ctrl 1 read wrong");
   read_two_a: assert property (rd_i && addr_i == 8'h06 && !$past(wr_i) |=>
      rdata_o[3:1] == $past({force_link_pass_o[1], power_save_disable_o[1],
      near_end_loopback_o[1]}) && {rdata_o[15:6], rdata_o[0]} == 11'h0)
      else $error("ctrl 2 read wrong");
   idle_read_a: assert property (!rd_i |=> rdata_o == 16'h0)
      else $error("data without read");
   diag_rsv_a: assert property (rd_i && addr_i == 8'h04 |=> rdata_o[11:9] == 3'h0)
      else $error("reserved bits set");
endmodule
bind pscd_bank pscd_chk chk_u (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .force_link_pass_o, .power_save_disable_o, .near_end_loopback_o, .diag_start_o);

// *** tb/pscd_eng.sv ***
// Purpose: Cable diagnostic engine model
// Assumes: Latency of lat_i+1 cycles after start
// Notes:   Results invert outside the done cycle
`timescale 1ns/1ps
module pscd_eng (
   input  wire logic        clk_i,
   input  wire logic        start_i,
   input  wire logic [3:0]  lat_i,
   input  wire logic [11:0] res_i,
   output logic             done_o,
   output logic [11:0]      res_o
);
   int cnt = -1;
   initial done_o = 1'b0;
   // Count down from start, then one done pulse
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (start_i) cnt <= lat_i;
      else if (cnt > 0) cnt <= cnt - 1;
      else if (cnt == 0) begin
         done_o <= 1'b1;
         cnt <= -1;
      end
   end
   assign res_o = done_o ? res_i : ~res_i;
endmodule

// *** tb/pscd_bank_tb.sv ***
// Purpose: Self-checking bench for the register bank
// Assumes: 200 MHz clock, reset held two cycles
// Notes:   Engine model answers diagnostics
`timescale 1ns/1ps
module pscd_bank_tb;
   import pscd_pkg::*;
   logic        clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, done, start, irq;
   logic [7:0]  addr_i = 0;
   logic [15:0] wdata_i = 0, q, d, rdata;
   logic [1:0]  pol = 0, xov = 0, fl, ps, lb;
   logic [11:0] res = 0, dres;
   logic [3:0]  lat = 4;
   logic [2:0]  c1 = 3'h2, c2 = 3'h2;
   int          n_errors = 0, compares = 0, k;
   always #2.5 clk_i = ~clk_i;
   pscd_bank dut_u (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o(rdata),
      .irq_o(irq), .polarity_reversed_i(pol), .crossover_state_i(xov), .force_link_pass_o(fl),
      .power_save_disable_o(ps), .near_end_loopback_o(lb), .diag_start_o(start),
      .diag_done_i(done), .diag_result_i(dres[11:10]), .diag_short_within_ten_metres_i(dres[9]),
      .diag_fault_count_i(dres[8:0]));
   pscd_eng eng_u (.clk_i, .start_i(start), .lat_i(lat), .res_i(res), .done_o(done),
      .res_o(dres));
   // Bus cycles and compare
   task wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_i); addr_i <= a; wdata_i <= v; wr_i <= 1;
      @(posedge clk_i); wr_i <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_i); addr_i <= a; rd_i <= 1;
      @(posedge clk_i); rd_i <= 0;
      #1 q = rdata;
   endtask
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task finish_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task irq_is(input logic e);
      repeat (2) @(posedge clk_i);
      #1 chk("irq", irq, e);
   endtask
   initial begin
      #20us n_errors++;
      finish_test;
   end
   // Main sequence
   initial begin
      void'($urandom(61));
      repeat (2) @(posedge clk_i);
      srst_i <= 0;
      rd(8'h02); chk("ctrl1", q, 16'h4);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         d = $urandom; pol <= $urandom; xov <= $urandom;
         wr(8'h02, d); c1 = d[3:1]; wr(8'h06, ~d); c2 = ~d[3:1];
         rd(8'h02); chk("ctrl1", q, {10'h0, pol[0], xov[0], c1, 1'b0});
         rd(8'h06); chk("ctrl2", q, {10'h0, pol[1], xov[1], c2, 1'b0});
         chk("ctl", {fl, ps, lb}, {c2[2], c1[2], c2[1], c1[1], c2[0], c1[0]});
      end
      rd(8'h00); chk("unmapped", q, 16'h0);
      wr(8'h0c, 16'h7); wr(8'h0a, 16'h1);
      for (int r = 0; r < 4; r++) begin
         res <= {r[1:0], 10'($urandom)}; lat <= 4'(1 + $urandom % 8);
         wr(8'h04, 16'hffff);
         rd(8'h04); chk("busy", q[15], 16'h1);
         k = 0;
         do begin rd(8'h04); k++; end while (q[15] && k < 20);
         chk("diag", q, {1'b0, res[11:9], 3'h0, res[8:0]});
         irq_is(1'b1); wr(8'h0c, 16'h1); irq_is(1'b0);
      end
      wr(8'h0a, 16'h0); pol <= ~pol; irq_is(1'b0);
      rd(8'h08); chk("status", q & 16'h6, 16'h6);
      wr(8'h0a, 16'h6); irq_is(1'b1); wr(8'h0c, 16'h7); irq_is(1'b0);
      rd(8'h0a); chk("irq_en", q, 16'h6);
      finish_test;
   end
endmodule
